/* File: design/dmarpf_core.sv */
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "dmarpf_defines.svh"
module dmarpf_core (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [1:0] external_request_n_i,
   input wire logic [5:0] periph_req_i,
   input wire logic nmi_i,
   output logic xfer_valid_o,
   output dmarpf_pkg::dmarpf_xfer_s xfer_o,
   input wire logic xfer_done_i,
   output logic [5:0] periph_ack_o,
   output logic [5:0] periph_irq_o,
   output logic [3:0] transfer_end_interrupt_o
);
   logic [15:0] ctl_r [4];
   logic [15:0] ctl_nxt [4];
   logic [23:0] cnt_r [4];
   logic [23:0] cnt_nxt [4];
   logic [3:0] te_rd_r, te_rd_nxt;
   logic [15:0] opr_r, opr_nxt;
   logic nmi_rd_r, nmi_rd_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] rdat_r, rdat_nxt;
   logic [1:0] ext_s1_r, ext_s2_r, ext_s3_r;
   logic [1:0] ext_pend_r, ext_pend_nxt;
   dmarpf_pkg::dmarpf_state_e st_r, st_nxt;
   dmarpf_pkg::dmarpf_xfer_s cur_r, cur_nxt;
   dmarpf_pkg::dmarpf_chan_t rr_r [4];
   dmarpf_pkg::dmarpf_chan_t rr_nxt [4];
   logic [5:0] pack_r, pack_nxt;
   logic [3:0] en, req;
   logic [5:0] used;
   logic done, acc;
   logic [1:0] pick;
   logic pick_ok;

   // Byte-lane merge of a bus write into an old register value.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            m[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   // External pins come from another domain, so two flops before use; the
   // third stage only serves falling-edge detection.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_s1_r <= 2'h3;
         ext_s2_r <= 2'h3;
         ext_s3_r <= 2'h3;
      end else begin
         ext_s1_r <= external_request_n_i;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   // Per-channel enable and request qualification.
   generate
      for (genvar c = 0; c < 4; c++) begin : g_ch
         logic [3:0] rs;
         logic ext_ok, per_ok;
         assign rs = ctl_r[c][`DMARPF_RS_LSB +: 4];
         assign en[c] = ctl_r[c][`DMARPF_DE_BIT] & opr_r[`DMARPF_DME_BIT] &
                        ~ctl_r[c][`DMARPF_TE_BIT] & ~opr_r[`DMARPF_NMI_FLAG_BIT];
         // External only on channels 0 and 1; DS picks level or latched edge.
         if (c < 2) begin : g_ext
            assign ext_ok = (rs == `DMARPF_RS_EXT) & (ctl_r[c][`DMARPF_DS_BIT] ?
                            ext_pend_r[c] : ~ext_s2_r[c]);
         end else begin : g_noext
            assign ext_ok = 1'b0;
         end
         assign per_ok = (rs >= `DMARPF_RS_PERIPH0) &
                         periph_req_i[3'(rs - `DMARPF_RS_PERIPH0)];
         assign req[c] = en[c] & ((rs == `DMARPF_RS_AUTO) | ext_ok | per_ok);
      end
   endgenerate

   // Peripheral lines claimed by an enabled channel are kept from the CPU.
   always_comb begin
      used = 6'h00;
      for (int c = 0; c < 4; c++) begin
         if (ctl_r[c][`DMARPF_DE_BIT] && ctl_r[c][`DMARPF_RS_LSB +: 4] >= `DMARPF_RS_PERIPH0) begin
            used[3'(ctl_r[c][`DMARPF_RS_LSB +: 4] - `DMARPF_RS_PERIPH0)] = 1'b1;
         end
      end
   end
   assign periph_irq_o = periph_req_i & ~used;

   // Priority pick: fixed orders are constants, round-robin uses the live list.
   always_comb begin
      dmarpf_pkg::dmarpf_chan_t ord [4];
      ord = '{2'h0, 2'h1, 2'h2, 2'h3};
      pick = 2'h0;
      pick_ok = 1'b0;
      unique case (opr_r[`DMARPF_PR_LSB +: 2])
         2'h0: ord = '{2'h0, 2'h1, 2'h2, 2'h3};
         2'h1: ord = '{2'h0, 2'h2, 2'h3, 2'h1};
         2'h2: ord = '{2'h2, 2'h0, 2'h1, 2'h3};
         2'h3: ord = rr_r;
      endcase
      for (int i = 3; i >= 0; i--) begin
         if (req[ord[i]]) begin
            pick = ord[i];
            pick_ok = 1'b1;
         end
      end
   end

   assign done = (st_r == dmarpf_pkg::ST_BUSY) & xfer_done_i & en[cur_r.ch];
   assign acc = wb_cyc_i & wb_stb_i & ~ack_r;

   // Transfer sequencing, count, flags and registers; one unit per grant.
   // A new pick is made in IDLE after every unit, so arbitration is fresh.
   always_comb begin
      logic [31:0] w;
      logic [5:0] a;
      logic [3:0] c;
      w = 32'h0000_0000;
      a = 6'h00;
      c = 4'h0;
      st_nxt = st_r;
      cur_nxt = cur_r;
      ctl_nxt = ctl_r;
      cnt_nxt = cnt_r;
      opr_nxt = opr_r;
      te_rd_nxt = te_rd_r;
      nmi_rd_nxt = nmi_rd_r;
      rr_nxt = rr_r;
      pack_nxt = 6'h00;
      ext_pend_nxt = ext_pend_r | (ext_s3_r & ~ext_s2_r);
      ack_nxt = acc;
      rdat_nxt = 32'h0000_0000;
      // Register bus access; ack follows one cycle after the request.
      if (acc) begin
         a = wb_adr_i[5:0];
         c = wb_adr_i[7:4];
         if (wb_adr_i == `DMARPF_OPR_OFF) begin
            rdat_nxt = {16'h0000, opr_r};
            if (!wb_we_i) begin
               nmi_rd_nxt = opr_r[`DMARPF_NMI_FLAG_BIT];
            end else begin
               w = merge({16'h0000, opr_r}, wb_dat_i, wb_sel_i);
               opr_nxt[`DMARPF_DME_BIT] = w[`DMARPF_DME_BIT];
               opr_nxt[`DMARPF_PR_LSB +: 2] = w[`DMARPF_PR_LSB +: 2];
               if (nmi_rd_r && !w[`DMARPF_NMI_FLAG_BIT]) begin
                  opr_nxt[`DMARPF_NMI_FLAG_BIT] = 1'b0;
               end
            end
         end else if (c < 4'h4 && (a[3:0] == `DMARPF_CTL_OFF || a[3:0] == `DMARPF_CNT_OFF)) begin
            if (a[3:0] == `DMARPF_CTL_OFF) begin
               rdat_nxt = {16'h0000, ctl_r[c[1:0]]};
               if (!wb_we_i) begin
                  te_rd_nxt[c[1:0]] = ctl_r[c[1:0]][`DMARPF_TE_BIT];
               end else begin
                  w = merge({16'h0000, ctl_r[c[1:0]]}, wb_dat_i, wb_sel_i);
                  ctl_nxt[c[1:0]] = (w[15:0] & ((c < 4'h2) ? `DMARPF_CTL_WMASK01 :
                     `DMARPF_CTL_WMASK23)) | (ctl_r[c[1:0]] & 16'h0002);
                  if (te_rd_r[c[1:0]] && !w[`DMARPF_TE_BIT]) begin
                     ctl_nxt[c[1:0]][`DMARPF_TE_BIT] = 1'b0;
                  end
               end
            end else begin
               rdat_nxt = {8'h00, cnt_r[c[1:0]]};
               if (wb_we_i) begin
                  w = merge({8'h00, cnt_r[c[1:0]]}, wb_dat_i, wb_sel_i);
                  cnt_nxt[c[1:0]] = w[23:0];
               end
            end
         end
      end
      // NMI sets its flag whether running or halted; set beats any clear.
      if (nmi_i) begin
         opr_nxt[`DMARPF_NMI_FLAG_BIT] = 1'b1;
      end
      unique case (st_r)
         dmarpf_pkg::ST_IDLE: begin
            if (pick_ok) begin
               st_nxt = dmarpf_pkg::ST_BUSY;
               cur_nxt.ch = pick;
               cur_nxt.size = ctl_r[pick][`DMARPF_TS_LSB +: 2];
               cur_nxt.last = (cnt_r[pick] == 24'h00_0001);
               if (pick < 2'h2) begin
                  ext_pend_nxt[pick[0]] = 1'b0;
               end
            end
         end
         dmarpf_pkg::ST_BUSY: begin
            // A unit that completes at the NMI edge still counts; the abort takes
            // the next one, so the count and the bus side never disagree.
            if (done) begin
               st_nxt = dmarpf_pkg::ST_IDLE;
               cnt_nxt[cur_r.ch] = cnt_r[cur_r.ch] - 24'h00_0001;
               if (cur_r.last) begin
                  ctl_nxt[cur_r.ch][`DMARPF_TE_BIT] = 1'b1;
               end
               // Served channel leaves its slot and goes to the bottom.
               for (int i = 0; i < 4; i++) begin
                  if (rr_r[i] == cur_r.ch) begin
                     for (int j = i; j < 3; j++) begin
                        rr_nxt[j] = rr_r[j+1];
                     end
                     rr_nxt[3] = cur_r.ch;
                  end
               end
               // Withdraw the peripheral line: every unit in cycle steal, last in burst.
               if (ctl_r[cur_r.ch][`DMARPF_RS_LSB +: 4] >= `DMARPF_RS_PERIPH0 &&
                   (!ctl_r[cur_r.ch][`DMARPF_TM_BIT] || cur_r.last)) begin
                  pack_nxt[3'(ctl_r[cur_r.ch][`DMARPF_RS_LSB +: 4] - `DMARPF_RS_PERIPH0)] =
                     1'b1;
               end
            end else if (!en[cur_r.ch] || nmi_i) begin
               st_nxt = dmarpf_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // State registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= dmarpf_pkg::ST_IDLE;
         cur_r <= '0;
         opr_r <= `DMARPF_OPR_RST;
         nmi_rd_r <= 1'b0;
         te_rd_r <= 4'h0;
         rr_r <= '{2'h0, 2'h1, 2'h2, 2'h3};
         pack_r <= 6'h00;
         ext_pend_r <= 2'h0;
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
         for (int c = 0; c < 4; c++) begin
            ctl_r[c] <= `DMARPF_CTL_RST;
            cnt_r[c] <= 24'h00_0000;
         end
      end else begin
         st_r <= st_nxt;
         cur_r <= cur_nxt;
         opr_r <= opr_nxt;
         nmi_rd_r <= nmi_rd_nxt;
         te_rd_r <= te_rd_nxt;
         rr_r <= rr_nxt;
         pack_r <= pack_nxt;
         ext_pend_r <= ext_pend_nxt;
         ack_r <= ack_nxt;
         rdat_r <= rdat_nxt;
         ctl_r <= ctl_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Outputs; the unit is offered only while its channel is still enabled.
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;
   assign xfer_valid_o = (st_r == dmarpf_pkg::ST_BUSY) & en[cur_r.ch];
   assign xfer_o = cur_r;
   assign periph_ack_o = pack_r;
   generate
      for (genvar c = 0; c < 4; c++) begin : g_irq
         assign transfer_end_interrupt_o[c] = ctl_r[c][`DMARPF_TE_BIT] &
                                              ctl_r[c][`DMARPF_IE_BIT];
      end
   endgenerate

   // Checks.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   nmi_flag_set_a: assert property (nmi_i |=> opr_r[`DMARPF_NMI_FLAG_BIT])
      else $error("NMI flag not set");
   nmi_abort_a: assert property (nmi_i |=> !xfer_valid_o)
      else $error("transfer offered after NMI");
   count_dec_a: assert property (done |=> cnt_r[$past(cur_r.ch)] ==
                                 $past(cnt_r[cur_r.ch]) - 24'h00_0001)
      else $error("count not decremented");
   end_flag_a: assert property (done && cur_r.last |=>
                                ctl_r[$past(cur_r.ch)][`DMARPF_TE_BIT])
      else $error("transfer end flag not set");
   enable_gate_a: assert property (xfer_valid_o |-> opr_r[`DMARPF_DME_BIT] &&
                                   !opr_r[`DMARPF_NMI_FLAG_BIT] &&
                                   ctl_r[xfer_o.ch][`DMARPF_DE_BIT] &&
                                   !ctl_r[xfer_o.ch][`DMARPF_TE_BIT])
      else $error("unit offered on disabled channel");
   fixed_first_a: assert property (st_r == dmarpf_pkg::ST_IDLE && req[0] &&
                                   opr_r[`DMARPF_PR_LSB +: 2] == 2'h0 |=> xfer_o.ch == 2'h0)
      else $error("fixed order not kept");
   rr_bottom_a: assert property (done |=> rr_r[3] == $past(cur_r.ch))
      else $error("served channel not lowest");
   irq_withheld_a: assert property ((periph_irq_o & used) == 6'h00)
      else $error("claimed interrupt forwarded");
   bus_ack_a: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack timing wrong");
   unit_cov: cover property (done);
   end_cov: cover property (done && cur_r.last);
   rr_cov: cover property (done && opr_r[`DMARPF_PR_LSB +: 2] == `DMARPF_PR_RR);
endmodule : dmarpf_core

/* File: design/dmarpf_defines.svh */
`ifndef DMARPF_DEFINES_SVH
`define DMARPF_DEFINES_SVH
// Register byte offsets: channel n control at 0x00 + 0x10*n, count at 0x04 + 0x10*n.
`define DMARPF_CH_STRIDE 8'h10
`define DMARPF_CTL_OFF 8'h00
`define DMARPF_CNT_OFF 8'h04
`define DMARPF_OPR_OFF 8'h40
// Channel control fields.
`define DMARPF_DE_BIT 0
`define DMARPF_TE_BIT 1
`define DMARPF_IE_BIT 2
`define DMARPF_TS_LSB 3
`define DMARPF_TM_BIT 5
`define DMARPF_DS_BIT 6
`define DMARPF_RS_LSB 8
`define DMARPF_CTL_WMASK01 16'h0F7D
`define DMARPF_CTL_WMASK23 16'h0F3D
`define DMARPF_CTL_RST 16'h0000
// Request source codes.
`define DMARPF_RS_EXT 4'h0
`define DMARPF_RS_AUTO 4'h4
`define DMARPF_RS_PERIPH0 4'hA
// Operation register fields.
`define DMARPF_DME_BIT 0
`define DMARPF_NMI_FLAG_BIT 1
`define DMARPF_PR_LSB 8
`define DMARPF_PR_RR 2'h3
`define DMARPF_OPR_RST 16'h0000
`define DMARPF_CNT_W 24
`endif

/* File: design/dmarpf_pkg.sv */
package dmarpf_pkg;
   typedef enum logic {ST_IDLE, ST_BUSY} dmarpf_state_e;
   // One transfer unit handed to the bus side.
   typedef struct packed {
      logic [1:0] ch;
      logic [1:0] size;
      logic last;
   } dmarpf_xfer_s;
   typedef logic [1:0] dmarpf_chan_t;
endpackage : dmarpf_pkg

/* File: tb/dmarpf_bus_model.sv */
`timescale 1ns/1ps
// Bus side that completes each offered unit, either at once or after a stall.
module dmarpf_bus_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic valid_i,
   input wire logic slow_i,
   output logic done_o
);
   logic [2:0] wait_r;
   // The requester need not be the data endpoint; the unit is finished regardless.
   always_ff @(posedge clk_i) begin
      if (rst_i || !valid_i || done_o) begin
         done_o <= 1'b0;
         wait_r <= slow_i ? 3'h7 : 3'h0;
      end else if (wait_r == 3'h0) begin
         done_o <= 1'b1;
      end else begin
         wait_r <= wait_r - 3'h1;
      end
   end
endmodule : dmarpf_bus_model

/* File: tb/dmarpf_core_tb_top.sv */
`timescale 1ns/1ps
module dmarpf_core_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, nmi = 1'b0, slow = 1'b0, done, valid;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, rdat, lf = 32'h09EE_7336;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [1:0] ext_n = 2'h3;
   logic [5:0] preq = 6'h00, pack, pirq;
   logic [3:0] tei;
   dmarpf_pkg::dmarpf_xfer_s xo;
   logic [1:0] gq[$];
   logic [2:0] sq[$];
   int fails = 0, tests_run = 0, pk = 0, n, acks = 0;
   dmarpf_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .external_request_n_i(ext_n), .periph_req_i(preq), .nmi_i(nmi),
      .xfer_valid_o(valid), .xfer_o(xo), .xfer_done_i(done), .periph_ack_o(pack),
      .periph_irq_o(pirq), .transfer_end_interrupt_o(tei));
   dmarpf_bus_model bm (.clk_i(clk_i), .rst_i(rst_i), .valid_i(valid), .slow_i(slow),
      .done_o(done));
   // Free-running 25 MHz clock.
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // Log channel, last flag and size of every completed unit; count withdraw pulses.
   always @(posedge clk_i) begin
      if (valid === 1'b1 && done === 1'b1) begin
         gq.push_back(xo.ch);
         sq.push_back({xo.last, xo.size});
      end
      if (rst_i) acks <= 0;
      else if (pack[pk] === 1'b1) acks <= acks + 1;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
   endfunction : lfsr
   // Expected channel of the i-th unit when all four channels run two units each.
   function automatic logic [31:0] exp_ch(input int m, input int i);
      logic [1:0] ord[3][4] = '{'{2'h0, 2'h1, 2'h2, 2'h3}, '{2'h0, 2'h2, 2'h3, 2'h1},
         '{2'h2, 2'h0, 2'h1, 2'h3}};
      return (m == 3) ? 32'(i % 4) : 32'(ord[m][i / 2]);
   endfunction : exp_ch
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("counts: %0d compares, %0d mismatches", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test
   // Classic single Wishbone cycle; the request is held until ack is seen.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && k < 50) begin
         @(posedge clk_i);
         k++;
      end
      if (k == 50) begin
         fails++;
         $display("MISMATCH %0t bus ack timeout", $time);
      end
      rdat = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask : rd
   task automatic reset_dut();
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      gq.delete();
      sq.delete();
   endtask : reset_dut
   task automatic wait_units(input int cnt);
      int k;
      for (k = 0; k < 2000 && gq.size() < cnt; k++) @(posedge clk_i);
      repeat (30) @(posedge clk_i);
      chk(gq.size(), cnt);
   endtask : wait_units
   // Watchdog well beyond the length of the whole sequence.
   initial begin
      repeat (60000) @(posedge clk_i);
      fails++;
      $display("MISMATCH %0t watchdog timeout", $time);
      end_of_test();
   end
   initial begin
      logic [1:0] sz;
      logic [15:0] cw;
      reset_dut();
      rd(8'h00, 32'h0);
      rd(8'h40, 32'h0);
      rd(8'h80, 32'h0);
      bus(1'b1, 8'h34, 32'hFFFF_FFFF);
      rd(8'h34, 32'h00FF_FFFF);
      $display("test registers done");
      // Every priority mode with all four auto-request channels started at once.
      for (int m = 0; m < 4; m++) begin
         reset_dut();
         lf = lfsr(lf);
         sz = 2'(lf % 3);
         for (int c = 0; c < 4; c++) begin
            bus(1'b1, 8'(c * 16 + 4), 32'h2);
            bus(1'b1, 8'(c * 16), {16'h0, 16'h0405 | (16'(sz) << 3)});
         end
         chk(valid, 1'b0);
         bus(1'b1, 8'h40, {16'h0, 6'h0, 2'(m), 8'h01});
         wait_units(8);
         for (int i = 0; i < 8; i++) chk(gq[i], exp_ch(m, i));
         // Two units per channel: the second of each pair, or the second lap, is last.
         for (int i = 0; i < 8; i++) chk(sq[i], {(m == 3) ? (i > 3) : i[0], sz});
         chk(tei, 4'hF);
         rd(8'h00, {16'h0, 16'h0407 | (16'(sz) << 3)});
         bus(1'b1, 8'h00, 32'h0);
         chk(tei, 4'hE);
         $display("test priority mode %0d done", m);
      end
      // NMI in mid-run with a stalled bus side.
      reset_dut();
      slow <= 1'b1;
      bus(1'b1, 8'h14, 32'h8);
      bus(1'b1, 8'h10, 32'h0401);
      bus(1'b1, 8'h40, 32'h1);
      for (int k = 0; k < 500 && gq.size() < 2; k++) @(posedge clk_i);
      nmi <= 1'b1;
      @(posedge clk_i);
      nmi <= 1'b0;
      repeat (20) @(posedge clk_i);
      n = gq.size();
      repeat (40) @(posedge clk_i);
      chk(gq.size(), n);
      rd(8'h40, 32'h3);
      rd(8'h14, 32'(8 - n));
      bus(1'b1, 8'h40, 32'h1);
      rd(8'h40, 32'h1);
      slow <= 1'b0;
      bus(1'b1, 8'h10, 32'h0);
      $display("test nmi abort done");
      // External pin: level on channel 0, one falling edge on channel 1.
      reset_dut();
      ext_n <= 2'h2;
      bus(1'b1, 8'h04, 32'h3);
      bus(1'b1, 8'h14, 32'h4);
      bus(1'b1, 8'h10, 32'h0041);
      bus(1'b1, 8'h00, 32'h0001);
      bus(1'b1, 8'h40, 32'h1);
      wait_units(3);
      ext_n <= 2'h3;
      repeat (5) @(posedge clk_i);
      ext_n <= 2'h1;
      wait_units(4);
      chk(gq[3], 32'h1);
      ext_n <= 2'h3;
      $display("test external request done");
      // A random peripheral line claimed by a random upper channel.
      for (int r = 0; r < 3; r++) begin
         reset_dut();
         lf = lfsr(lf);
         pk = lf % 6;
         n = 2 + lf[8];
         // All six lines are raised at once, before the channel is set up.
         preq <= 6'h3F;
         // The middle round runs in burst, so its line is withdrawn only at the last unit.
         cw = 16'h0A01 + (16'(pk) << 8) + ((r == 1) ? 16'h0020 : 16'h0000);
         bus(1'b1, 8'(n * 16 + 4), 32'h2);
         bus(1'b1, 8'(n * 16), {16'h0000, cw});
         chk(pirq, 32'(6'h3F & ~(6'h1 << pk)));
         bus(1'b1, 8'h40, 32'h1);
         wait_units(2);
         chk(gq[0], 32'(n));
         chk(gq[1], 32'(n));
         chk(acks, (r == 1) ? 32'h1 : 32'h2);
         preq <= 6'h00;
         $display("test peripheral line %0d done", pk);
      end
      end_of_test();
   end
endmodule : dmarpf_core_tb_top
